// ==== fsc_flash_ctrl.sv ====
// How it works
// [RQ1] Read with CE, OE low, WE high
// [RQ2] Bus released whenever CE or OE high
// [RQ3] Device starts in read mode; commands otherwise
// [RQ4] Command codes in low byte, upper zero
// [RQ5] Write: WE pulse with CE low, OE high
// [RQ6] Data held through first rising strobe edge
// [RQ7] Reset low aborts operation, bus floats
// [RQ8] After reset device returns to read
// [RQ9] Erased bits read one; erase before reprogramming
// [RQ10] Chip erase is six cycles, self-timed
// [RQ11] Chip erase skips locked sectors
// [RQ12] Sector erase: six cycles, sector address, 30H
// [RQ13] Protected sector erase ends in 2 us
// [RQ14] Word program is four cycles, self-timed
// [RQ15] Commands during programming are ignored
// [RQ16] Programming never turns zero into one
// [RQ17] Reset during programming corrupts that word
// [RQ18] Status mode 00 or 01, set by command
// [RQ19] Mode 01 needs exit command after success
// [RQ20] Any failure needs exit command
// [RQ21] Status mode survives reset pin
// [RQ22] Mode 00: poll bit complemented or zero
// [RQ23] Mode 01: poll bit low until done
// [RQ24] Toggle bit flips each read while busy
// [RQ25] Fail bit high on failure
// [RQ26] Mismatched write abandons sequence to read
//
// The placing of the registers and strobed register access were left to the implementer.
module fsc_flash_ctrl #(
  parameter int POLL_LIMIT = 2000000
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Software register port
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // Flash pins
  output logic [19:0] FLASH_ADDR,
  input wire logic [15:0] FLASH_DQ_I,
  output logic [15:0] FLASH_DQ_O,
  output logic FLASH_DQ_OE,
  output logic FLASH_CE_N,
  output logic FLASH_OE_N,
  output logic FLASH_WE_N,
  output logic FLASH_RESET_N
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_SEQ, ST_SEQ_WAIT, ST_POLL1, ST_POLL1_WAIT, ST_POLL2, ST_POLL2_WAIT,
    ST_EXIT, ST_EXIT_WAIT, ST_READ_WAIT, ST_RST_LOW, ST_RST_REC
  } fsc_state_t;

  fsc_state_t state_q;
  logic [2:0] op_q, step_q;
  logic [19:0] addr_q, cyc_addr_q;
  logic [15:0] wdata_q, rdata_q, cyc_data_q, cyc_rdata;
  logic [1:0] cfg_new_q, cfg_q;
  logic [7:0] rst_cnt_q;
  logic [31:0] poll_cnt_q;
  logic tog_q, done_q, fail_q, tmo_q, cyc_start_q, cyc_wr_q, cyc_done;
  logic [35:0] seq_word, exit_word;
  logic seq_last, exit_last, op_go, poll_fin;

  // Number of bus cycles in each command sequence
  function automatic logic [2:0] seq_len(input logic [2:0] op);
    case (op)
      fsc_pkg::OP_PROGRAM: seq_len = 3'h4; // [RQ14]
      fsc_pkg::OP_SET_CONFIG: seq_len = 3'h4; // [RQ18]
      fsc_pkg::OP_ID_EXIT: seq_len = 3'h3;
      default: seq_len = 3'h6; // [RQ10] [RQ12]
    endcase
  endfunction : seq_len

  // Address and data of one step of a command sequence; codes use the low byte only
  function automatic logic [35:0] seq_step(input logic [2:0] op, input logic [2:0] idx,
                                           input logic [19:0] a, input logic [15:0] d,
                                           input logic [1:0] c);
    logic [35:0] r;
    r = {fsc_pkg::UNLOCK1_ADDR, 8'h00, fsc_pkg::UNLOCK1_DATA}; // [RQ4]
    case (idx)
      3'h1, 3'h4: r = {fsc_pkg::UNLOCK2_ADDR, 8'h00, fsc_pkg::UNLOCK2_DATA};
      3'h2: begin
        case (op)
          fsc_pkg::OP_PROGRAM: r = {fsc_pkg::UNLOCK1_ADDR, 8'h00, fsc_pkg::CMD_PROGRAM};
          fsc_pkg::OP_SET_CONFIG: r = {fsc_pkg::UNLOCK1_ADDR, 8'h00, fsc_pkg::CMD_SET_CONFIG};
          fsc_pkg::OP_ID_EXIT: r = {fsc_pkg::UNLOCK1_ADDR, 8'h00, fsc_pkg::CMD_ID_EXIT};
          default: r = {fsc_pkg::UNLOCK1_ADDR, 8'h00, fsc_pkg::CMD_ERASE};
        endcase
      end
      3'h3: begin
        if (op == fsc_pkg::OP_PROGRAM) begin
          r = {a, d}; // Word address and data, full 16 bits [RQ14]
        end else if (op == fsc_pkg::OP_SET_CONFIG) begin
          r = {fsc_pkg::UNLOCK1_ADDR, 14'h0000, c}; // [RQ18]
        end
      end
      3'h5: begin
        if (op == fsc_pkg::OP_CHIP_ERASE) begin
          r = {fsc_pkg::UNLOCK1_ADDR, 8'h00, fsc_pkg::CMD_CHIP_ERASE}; // [RQ10] [RQ11]
        end else begin
          r = {a, 8'h00, fsc_pkg::CMD_SECTOR_ERASE}; // Sector address on last cycle [RQ12]
        end
      end
      default: r = {fsc_pkg::UNLOCK1_ADDR, 8'h00, fsc_pkg::UNLOCK1_DATA};
    endcase
    return r;
  endfunction : seq_step

  // Step decode for the running command and for the exit command
  assign seq_word = seq_step(op_q, step_q, addr_q, wdata_q, cfg_new_q);
  assign exit_word = seq_step(fsc_pkg::OP_ID_EXIT, step_q, addr_q, wdata_q, cfg_new_q);
  assign seq_last = (step_q == seq_len(op_q) - 3'h1);
  assign exit_last = (step_q == seq_len(fsc_pkg::OP_ID_EXIT) - 3'h1);
  assign op_go = REG_WR && (REG_ADDR == fsc_pkg::REG_CTRL) && (state_q == ST_IDLE);

  // Operation complete: toggle stopped and, in mode 01, poll bit high
  assign poll_fin = (cyc_rdata[fsc_pkg::TOGGLE_BIT] == tog_q) && // [RQ24]
                    ((cfg_q != fsc_pkg::CFG_HOLD_STATUS) ||
                     cyc_rdata[fsc_pkg::POLL_BIT]); // [RQ23]

  // Operand registers, written only while idle so a running operation is never disturbed
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      addr_q <= 20'h00000;
      wdata_q <= 16'h0000;
      cfg_new_q <= 2'h0;
      op_q <= 3'h0;
    end else if (REG_WR && state_q == ST_IDLE) begin
      case (REG_ADDR)
        fsc_pkg::REG_ADDR: addr_q <= REG_WDATA[19:0];
        fsc_pkg::REG_WDATA: wdata_q <= REG_WDATA[15:0];
        fsc_pkg::REG_CFG: cfg_new_q <= REG_WDATA[1:0];
        fsc_pkg::REG_CTRL: op_q <= REG_WDATA[2:0];
        default: ;
      endcase
    end
  end

  // Operation sequencer
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_q <= ST_IDLE;
      step_q <= 3'h0;
      rst_cnt_q <= 8'h00;
      poll_cnt_q <= 32'h0000_0000;
      tog_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      tmo_q <= 1'b0;
      rdata_q <= 16'h0000;
      cfg_q <= fsc_pkg::CFG_AUTO_READ; // Power-up default 00 [RQ18]
      cyc_start_q <= 1'b0;
      cyc_wr_q <= 1'b0;
      cyc_addr_q <= 20'h00000;
      cyc_data_q <= 16'h0000;
      FLASH_RESET_N <= 1'b1;
    end else begin
      cyc_start_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (op_go) begin
            done_q <= 1'b0;
            fail_q <= 1'b0;
            tmo_q <= 1'b0;
            step_q <= 3'h0;
            case (REG_WDATA[2:0])
              fsc_pkg::OP_READ: begin
                cyc_start_q <= 1'b1; // Plain array read [RQ1] [RQ3]
                cyc_wr_q <= 1'b0;
                cyc_addr_q <= addr_q;
                state_q <= ST_READ_WAIT;
              end
              fsc_pkg::OP_RESET: begin
                FLASH_RESET_N <= 1'b0; // Aborts any flash operation [RQ7] [RQ17]
                rst_cnt_q <= fsc_pkg::C_RESET_LOW - 8'h01;
                state_q <= ST_RST_LOW;
              end
              fsc_pkg::OP_ID_EXIT: state_q <= ST_EXIT;
              default: state_q <= ST_SEQ;
            endcase
          end
        end
        ST_SEQ: begin
          cyc_start_q <= 1'b1;
          cyc_wr_q <= 1'b1;
          cyc_addr_q <= seq_word[35:16];
          cyc_data_q <= seq_word[15:0];
          state_q <= ST_SEQ_WAIT;
        end
        ST_SEQ_WAIT: begin
          if (cyc_done) begin
            // Sequences are always issued whole, never abandoned midway [RQ26]
            if (seq_last) begin
              if (op_q == fsc_pkg::OP_SET_CONFIG) begin
                cfg_q <= cfg_new_q; // Only this command changes the mode [RQ18] [RQ21]
                done_q <= 1'b1;
                state_q <= ST_IDLE;
              end else begin
                poll_cnt_q <= 32'h0000_0000;
                state_q <= ST_POLL1;
              end
            end else begin
              step_q <= step_q + 3'h1;
              state_q <= ST_SEQ;
            end
          end
        end
        ST_POLL1, ST_POLL2: begin
          // Status reads only while busy; no command is written [RQ15]
          cyc_start_q <= 1'b1;
          cyc_wr_q <= 1'b0;
          cyc_addr_q <= addr_q; // Last loaded word for program polling [RQ22]
          state_q <= (state_q == ST_POLL1) ? ST_POLL1_WAIT : ST_POLL2_WAIT;
        end
        ST_POLL1_WAIT: begin
          if (cyc_done) begin
            tog_q <= cyc_rdata[fsc_pkg::TOGGLE_BIT];
            rdata_q <= cyc_rdata; // First word of the pair, kept for the fail check
            state_q <= ST_POLL2;
          end
        end
        ST_POLL2_WAIT: begin
          if (cyc_done) begin
            rdata_q <= cyc_rdata;
            step_q <= 3'h0;
            // Settled array data may hold a one in the fail bit (erased words do), so the
            // fail bit counts only while poll_fin is false (toggle running, or poll bit low in mode 01) and on both reads of the pair [RQ9]
            if (poll_fin) begin
              if (cfg_q == fsc_pkg::CFG_HOLD_STATUS) begin
                state_q <= ST_EXIT; // [RQ19]
              end else begin
                done_q <= 1'b1; // Device back in read mode by itself [RQ19]
                state_q <= ST_IDLE;
              end
            end else if (cyc_rdata[fsc_pkg::FAIL_BIT] && rdata_q[fsc_pkg::FAIL_BIT]) begin
              fail_q <= 1'b1; // Failed, protected or zero raised to one [RQ25] [RQ13] [RQ16]
              state_q <= ST_EXIT; // Exit needed after failure [RQ20]
            end else if (poll_cnt_q == 32'(POLL_LIMIT)) begin
              tmo_q <= 1'b1;
              fail_q <= 1'b1;
              state_q <= ST_EXIT;
            end else begin
              poll_cnt_q <= poll_cnt_q + 32'h0000_0001;
              state_q <= ST_POLL1;
            end
          end
        end
        ST_EXIT: begin
          cyc_start_q <= 1'b1;
          cyc_wr_q <= 1'b1;
          cyc_addr_q <= exit_word[35:16];
          cyc_data_q <= exit_word[15:0];
          state_q <= ST_EXIT_WAIT;
        end
        ST_EXIT_WAIT: begin
          if (cyc_done) begin
            if (exit_last) begin
              done_q <= 1'b1;
              state_q <= ST_IDLE;
            end else begin
              step_q <= step_q + 3'h1;
              state_q <= ST_EXIT;
            end
          end
        end
        ST_READ_WAIT: begin
          if (cyc_done) begin
            rdata_q <= cyc_rdata;
            done_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        ST_RST_LOW: begin
          if (rst_cnt_q == 8'h00) begin
            FLASH_RESET_N <= 1'b1; // Device resumes in read mode [RQ8]
            rst_cnt_q <= fsc_pkg::C_RESET_REC - 8'h01;
            state_q <= ST_RST_REC;
          end else begin
            rst_cnt_q <= rst_cnt_q - 8'h01;
          end
        end
        ST_RST_REC: begin
          if (rst_cnt_q == 8'h00) begin
            done_q <= 1'b1;
            state_q <= ST_IDLE;
          end else begin
            rst_cnt_q <= rst_cnt_q - 8'h01;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Register read port, data valid the cycle after the strobe
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 32'h0000_0000;
    end else if (REG_RD) begin
      REG_RDATA <= 32'h0000_0000;
      case (REG_ADDR)
        fsc_pkg::REG_CTRL: REG_RDATA[2:0] <= op_q;
        fsc_pkg::REG_ADDR: REG_RDATA[19:0] <= addr_q;
        fsc_pkg::REG_WDATA: REG_RDATA[15:0] <= wdata_q;
        fsc_pkg::REG_CFG: REG_RDATA[1:0] <= cfg_new_q;
        fsc_pkg::REG_STATUS: begin
          REG_RDATA[fsc_pkg::ST_BUSY_BIT] <= (state_q != ST_IDLE);
          REG_RDATA[fsc_pkg::ST_DONE_BIT] <= done_q;
          REG_RDATA[fsc_pkg::ST_FAIL_BIT] <= fail_q;
          REG_RDATA[fsc_pkg::ST_TMO_BIT] <= tmo_q;
          REG_RDATA[fsc_pkg::ST_CFG_LSB +: 2] <= cfg_q;
        end
        fsc_pkg::REG_RDATA: REG_RDATA[15:0] <= rdata_q;
        default: ;
      endcase
    end
  end

  // Single flash bus cycle engine
  fsc_bus_cycle u_cycle (
    .clk(CLK_SYS), .rst(RST), .start(cyc_start_q), .is_write(cyc_wr_q),
    .addr(cyc_addr_q), .wdata(cyc_data_q), .done(cyc_done), .rdata(cyc_rdata),
    .fl_addr(FLASH_ADDR), .dq_i(FLASH_DQ_I), .dq_o(FLASH_DQ_O), .dq_oe(FLASH_DQ_OE),
    .ce_n(FLASH_CE_N), .oe_n(FLASH_OE_N), .we_n(FLASH_WE_N)
  );

endmodule : fsc_flash_ctrl

// ==== fsc_pkg.sv ====
package fsc_pkg;

  // Clock period of CLK_SYS
  localparam int CLK_PERIOD_NS = 20;

  // Flash bus timing, in nanoseconds
  localparam int T_SETUP_NS = 20;
  localparam int T_WP_NS = 50;
  localparam int T_ACC_NS = 90;
  localparam int T_HOLD_NS = 20;
  localparam int T_RESET_LOW_NS = 500;
  localparam int T_RESET_REC_NS = 200;

  // Least time rounds up to whole cycles, never below one
  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ceil_cyc

  localparam logic [7:0] C_SETUP = 8'(ceil_cyc(T_SETUP_NS));
  localparam logic [7:0] C_WP = 8'(ceil_cyc(T_WP_NS));
  localparam logic [7:0] C_ACC = 8'(ceil_cyc(T_ACC_NS));
  localparam logic [7:0] C_HOLD = 8'(ceil_cyc(T_HOLD_NS));
  localparam logic [7:0] C_RESET_LOW = 8'(ceil_cyc(T_RESET_LOW_NS));
  localparam logic [7:0] C_RESET_REC = 8'(ceil_cyc(T_RESET_REC_NS));

  // Software register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_CFG = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RDATA = 4'h5;

  // Status register fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_FAIL_BIT = 2;
  localparam int ST_TMO_BIT = 3;
  localparam int ST_CFG_LSB = 4;

  // Operation codes written to the control register
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_PROGRAM = 3'h1;
  localparam logic [2:0] OP_CHIP_ERASE = 3'h2;
  localparam logic [2:0] OP_SECTOR_ERASE = 3'h3;
  localparam logic [2:0] OP_SET_CONFIG = 3'h4;
  localparam logic [2:0] OP_ID_EXIT = 3'h5;
  localparam logic [2:0] OP_RESET = 3'h6;

  // Command sequence addresses and codes
  localparam logic [19:0] UNLOCK1_ADDR = 20'h00555;
  localparam logic [19:0] UNLOCK2_ADDR = 20'h002AA;
  localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_SET_CONFIG = 8'hE0;
  localparam logic [7:0] CMD_ID_EXIT = 8'hF0;

  // Status-mode setting values
  localparam logic [1:0] CFG_AUTO_READ = 2'h0;
  localparam logic [1:0] CFG_HOLD_STATUS = 2'h1;

  // Status bit positions on the data bus
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int FAIL_BIT = 5;

endpackage : fsc_pkg

// ==== fsc_bus_cycle.sv ====
module fsc_bus_cycle (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Cycle request
  input wire logic start,
  input wire logic is_write,
  input wire logic [19:0] addr,
  input wire logic [15:0] wdata,
  output logic done,
  output logic [15:0] rdata,
  // Flash pins
  output logic [19:0] fl_addr,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic dq_oe,
  output logic ce_n,
  output logic oe_n,
  output logic we_n
);

  typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD} fsc_cyc_t;

  fsc_cyc_t state_q;
  logic [7:0] cnt_q;
  logic wr_q;

  // One flash bus cycle: setup, strobe, hold
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= CY_IDLE;
      cnt_q <= 8'h00;
      wr_q <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
      fl_addr <= 20'h00000;
      dq_o <= 16'h0000;
      dq_oe <= 1'b0;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
    end else begin
      done <= 1'b0;
      case (state_q)
        CY_IDLE: begin
          if (start) begin
            wr_q <= is_write;
            fl_addr <= addr;
            ce_n <= 1'b0;
            oe_n <= 1'b1;
            dq_o <= wdata;
            dq_oe <= is_write;
            cnt_q <= fsc_pkg::C_SETUP - 8'h01;
            state_q <= CY_SETUP;
          end
        end
        CY_SETUP: begin
          if (cnt_q == 8'h00) begin
            // Write pulses WE low with CE low and OE high [RQ5]
            if (wr_q) begin
              we_n <= 1'b0;
              cnt_q <= fsc_pkg::C_WP - 8'h01;
            end else begin
              oe_n <= 1'b0; // Read with WE high, bus released [RQ1]
              cnt_q <= fsc_pkg::C_ACC - 8'h01;
            end
            state_q <= CY_STROBE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        CY_STROBE: begin
          if (cnt_q == 8'h00) begin
            if (wr_q) begin
              we_n <= 1'b1; // Data still driven on this first rising edge [RQ6]
            end else begin
              rdata <= dq_i;
              oe_n <= 1'b1; // Device releases the bus after this [RQ2]
            end
            cnt_q <= fsc_pkg::C_HOLD - 8'h01;
            state_q <= CY_HOLD;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        CY_HOLD: begin
          if (cnt_q == 8'h00) begin
            ce_n <= 1'b1;
            dq_oe <= 1'b0;
            done <= 1'b1;
            state_q <= CY_IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: state_q <= CY_IDLE;
      endcase
    end
  end

endmodule : fsc_bus_cycle

// ==== fsc_flash_ctrl_checker.sv ====
module fsc_flash_ctrl_checker (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Flash pins
  input wire logic [19:0] FLASH_ADDR,
  input wire logic [15:0] FLASH_DQ_O,
  input wire logic FLASH_DQ_OE,
  input wire logic FLASH_CE_N,
  input wire logic FLASH_OE_N,
  input wire logic FLASH_WE_N,
  input wire logic FLASH_RESET_N
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // Write pulse held low three cycles, then released
  sequence s_we_low;
    (!FLASH_WE_N)[*3] ##1 FLASH_WE_N;
  endsequence
  // Reset pulse held low for a good stretch
  sequence s_rst_low;
    (!FLASH_RESET_N)[*8];
  endsequence

  // Pin protocol checks
  a_strobe_excl: assert property (!(!FLASH_OE_N && !FLASH_WE_N))
    else $error("Output and write strobes low together");
  a_we_frame: assert property ($fell(FLASH_WE_N) |-> !FLASH_CE_N && FLASH_OE_N && FLASH_DQ_OE)
    else $error("Write pulse without select or driven data");
  a_we_width: assert property ($fell(FLASH_WE_N) |-> s_we_low)
    else $error("Write pulse width wrong");
  a_data_hold: assert property ($rose(FLASH_WE_N) |-> FLASH_DQ_OE && !FLASH_CE_N && $stable(FLASH_DQ_O) && $stable(FLASH_ADDR))
    else $error("Write data or address moved before strobe rise");
  a_cmd_byte: assert property ($fell(FLASH_WE_N) && FLASH_ADDR == 20'h00555 |-> FLASH_DQ_O[15:8] == 8'h00)
    else $error("Command word has upper byte set");
  a_read_release: assert property (!FLASH_OE_N |-> !FLASH_CE_N && !FLASH_DQ_OE)
    else $error("Read without select or with host driving");
  a_oe_after_ce: assert property ($fell(FLASH_OE_N) |-> !$past(FLASH_CE_N))
    else $error("Output gate fell before select");
  a_ce_gap: assert property ($rose(FLASH_CE_N) |=> FLASH_CE_N)
    else $error("Select reasserted without gap");
  a_reset_low: assert property ($fell(FLASH_RESET_N) |-> s_rst_low ##[1:40] FLASH_RESET_N)
    else $error("Flash reset pulse length wrong");
  a_reset_quiet: assert property (!FLASH_RESET_N |-> FLASH_CE_N && FLASH_WE_N && !FLASH_DQ_OE)
    else $error("Bus active during flash reset");
endmodule : fsc_flash_ctrl_checker

// ==== fsc_flash_model.sv ====
module fsc_flash_model #(
  parameter int T_PROG_NS = 1000,
  parameter int T_ERASE_NS = 3000,
  parameter logic [4:0] LOCK_SECT = 5'h07
) (
  // Flash pins
  input wire logic [19:0] addr,
  input wire logic [15:0] dq_in,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic reset_n,
  output logic [15:0] dq_out,
  output logic dq_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [logic [19:0]];
  logic [19:0] la = '0;
  logic [19:0] pa = '0;
  logic [15:0] pd = '0;
  logic [1:0] mode = 2'h0;
  logic busy = 0, stat = 0, fail = 0, ers = 0, chip = 0, tog = 0;
  int step = 0;
  event go;

  // Unwritten words read as erased
  function automatic logic [15:0] rd(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction : rd

  // One word preloaded in the locked sector (sectors coarsened to addr[19:15])
  initial mem[{LOCK_SECT, 15'h0100}] = 16'h1234;

  // Address taken on the later falling strobe
  always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n) la = addr;

  // Command decoder on first rising strobe, low byte only, busy writes dropped
  always @(posedge we_n or posedge ce_n) begin
    if (we_n != ce_n && oe_n && reset_n && !busy) begin
      case (step)
        0: step = (la == 20'h00555 && dq_in[7:0] == 8'hAA) ? 1 : 0;
        1: step = (la == 20'h002AA && dq_in[7:0] == 8'h55) ? 2 : 0;
        2: begin
          step = 0;
          if (la == 20'h00555 && dq_in[7:0] == 8'hA0) step = 3;
          if (la == 20'h00555 && dq_in[7:0] == 8'hE0) step = 4;
          if (la == 20'h00555 && dq_in[7:0] == 8'h80) step = 5;
          if (la == 20'h00555 && dq_in[7:0] == 8'hF0) stat = 0;
        end
        3: begin
          step = 0; pa = la; pd = dq_in; ers = 0; ->go;
        end
        4: begin
          step = 0; mode = {1'b0, dq_in[0]};
        end
        5: step = (la == 20'h00555 && dq_in[7:0] == 8'hAA) ? 6 : 0;
        6: step = (la == 20'h002AA && dq_in[7:0] == 8'h55) ? 7 : 0;
        7: begin
          step = 0; pa = la; ers = 1; chip = (dq_in[7:0] == 8'h10);
          if (chip || dq_in[7:0] == 8'h30) ->go;
        end
        default: step = 0;
      endcase
    end
  end

  // Self-timed program and erase
  always begin : run
    logic [19:0] q[$];
    @(go);
    busy = 1; fail = 0; tog = 0;
    if (pa[19:15] == LOCK_SECT && !(ers && chip)) begin
      #2000; fail = 1;
    end else if (!ers) begin
      #(T_PROG_NS); fail = |(pd & ~rd(pa)); mem[pa] = rd(pa) & pd;
    end else begin
      #(T_ERASE_NS); q.delete();
      foreach (mem[k]) if (chip ? k[19:15] != LOCK_SECT : k[19:15] == pa[19:15]) q.push_back(k);
      foreach (q[i]) mem.delete(q[i]);
    end
    busy = 0; stat = fail || mode == 2'h1;
  end

  // Hardware reset aborts, spoils the word in flight, keeps the mode
  always @(negedge reset_n) begin
    if (busy && !ers) mem[pa] = ~pd;
    disable run;
    busy = 0; stat = 0; step = 0;
  end

  // Toggle bit flips on each read while busy, and after a failure that never completed
  always @(negedge oe_n) if (!ce_n && (busy || (stat && fail))) tog = ~tog;

  // Read path and status words
  assign dq_oe = !ce_n && !oe_n && we_n && reset_n;
  always @* begin
    if (busy) dq_out = {8'h00, (mode == 2'h0 && !ers) ? ~pd[7] : 1'b0, tog, 6'h00};
    else if (stat) dq_out = {8'h00, 1'b1, tog, fail, 5'h00};
    else dq_out = rd(addr);
  end
endmodule : fsc_flash_model

// ==== fsc_flash_ctrl_tb.sv ====
module fsc_flash_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [19:0] LOCK_A = 20'h38100;
  logic CLK_SYS = 0, RST = 1, REG_WR = 0, REG_RD = 0, noise = 0;
  logic [3:0] REG_ADDR = '0;
  logic [31:0] REG_WDATA = '0, REG_RDATA, st, seed = 32'd76;
  logic [19:0] FLASH_ADDR, pa;
  logic [15:0] FLASH_DQ_I, FLASH_DQ_O, m_dq, m_in, d1, d2;
  logic FLASH_DQ_OE, FLASH_CE_N, FLASH_OE_N, FLASH_WE_N, FLASH_RESET_N, m_oe;
  logic [1:0] mode = 2'h0;
  int failures = 0, compares = 0;

  // Clock, and a changing level on a bus nobody drives
  always #10 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) noise <= ~noise;
  assign m_in = FLASH_DQ_OE ? FLASH_DQ_O : {16{noise}};
  assign FLASH_DQ_I = m_oe ? m_dq : m_in;

  fsc_flash_ctrl #(.POLL_LIMIT(20)) i_fsc_flash_ctrl (.CLK_SYS(CLK_SYS), .RST(RST),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .FLASH_ADDR(FLASH_ADDR), .FLASH_DQ_I(FLASH_DQ_I),
    .FLASH_DQ_O(FLASH_DQ_O), .FLASH_DQ_OE(FLASH_DQ_OE), .FLASH_CE_N(FLASH_CE_N),
    .FLASH_OE_N(FLASH_OE_N), .FLASH_WE_N(FLASH_WE_N), .FLASH_RESET_N(FLASH_RESET_N));
  fsc_flash_model i_fsc_flash_model (.addr(FLASH_ADDR), .dq_in(m_in), .ce_n(FLASH_CE_N),
    .oe_n(FLASH_OE_N), .we_n(FLASH_WE_N), .reset_n(FLASH_RESET_N), .dq_out(m_dq), .dq_oe(m_oe));

  // Repeatable random source
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13; x ^= x >> 17; x ^= x << 5;
    return x;
  endfunction : xs

  // Expected status word after an operation
  function automatic logic [31:0] exp_st(input logic f);
    return {26'h0, mode, 1'b0, f, 1'b1, 1'b0};
  endfunction : exp_st

  task stop_test;
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // Register port cycles
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK_SYS); REG_WR <= 1'b1; REG_ADDR <= a; REG_WDATA <= d;
    @(posedge CLK_SYS); REG_WR <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge CLK_SYS); REG_RD <= 1'b1; REG_ADDR <= a;
    @(posedge CLK_SYS); REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask : rd

  // Start an operation, wait for idle, check the status word
  task op(input logic [2:0] code, input logic [19:0] a, input logic [15:0] d, input logic f);
    int n;
    wr(fsc_pkg::REG_ADDR, 32'(a)); wr(fsc_pkg::REG_WDATA, 32'(d));
    wr(fsc_pkg::REG_CTRL, 32'(code));
    n = 0; st = 32'h1;
    while (st[0] !== 1'b0 && n < 20000) begin
      rd(fsc_pkg::REG_STATUS, st); n++;
    end
    if (n == 20000) begin
      failures++; stop_test();
    end
    cmp(st, exp_st(f));
  endtask : op

  // Read one flash word through the controller
  task rdw(input logic [19:0] a, input logic [15:0] e);
    op(fsc_pkg::OP_READ, a, 16'h0, 1'b0);
    rd(fsc_pkg::REG_RDATA, st); cmp(st, 32'(e));
  endtask : rdw

  task set_mode(input logic [1:0] m);
    wr(fsc_pkg::REG_CFG, 32'(m)); mode = m;
    op(fsc_pkg::OP_SET_CONFIG, 20'h0, 16'h0, 1'b0);
  endtask : set_mode

  // Main sequence
  initial begin
    repeat (10) @(posedge CLK_SYS);
    RST <= 1'b0;
    rd(fsc_pkg::REG_STATUS, st); cmp(st, 32'h0);
    rd(4'hF, st); cmp(st, 32'h0);
    $display("Test done: reset state");
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed); pa = {5'h02, seed[14:0]}; d1 = seed[31:16];
      seed = xs(seed); d2 = (i == 0) ? d1 : seed[15:0];
      rdw(pa, 16'hFFFF);
      op(fsc_pkg::OP_PROGRAM, pa, d1, 1'b0);
      rdw(pa, d1);
      op(fsc_pkg::OP_PROGRAM, pa, d2, (d2 & ~d1) != 16'h0);
      rdw(pa, d1 & d2);
    end
    $display("Test done: program and reprogram");
    set_mode(2'h1);
    seed = xs(seed); pa = {5'h03, seed[14:0]}; d1 = seed[31:16];
    op(fsc_pkg::OP_PROGRAM, pa, d1, 1'b0);
    rdw(pa, d1);
    op(fsc_pkg::OP_RESET, 20'h0, 16'h0, 1'b0);
    rdw(pa, d1);
    op(fsc_pkg::OP_SECTOR_ERASE, LOCK_A, 16'h0, 1'b1);
    rdw(LOCK_A, 16'h1234);
    $display("Test done: hold-status mode and reset");
    set_mode(2'h0);
    op(fsc_pkg::OP_SECTOR_ERASE, pa, 16'h0, 1'b0);
    rdw(pa, 16'hFFFF);
    op(fsc_pkg::OP_PROGRAM, pa, d1, 1'b0);
    op(fsc_pkg::OP_CHIP_ERASE, 20'h0, 16'h0, 1'b0);
    rdw(pa, 16'hFFFF);
    rdw(LOCK_A, 16'h1234);
    op(fsc_pkg::OP_ID_EXIT, 20'h0, 16'h0, 1'b0);
    $display("Test done: erase");
    stop_test();
  end
endmodule : fsc_flash_ctrl_tb

bind fsc_flash_ctrl fsc_flash_ctrl_checker i_fsc_flash_ctrl_checker (.CLK_SYS(CLK_SYS),
  .RST(RST), .FLASH_ADDR(FLASH_ADDR), .FLASH_DQ_O(FLASH_DQ_O), .FLASH_DQ_OE(FLASH_DQ_OE),
  .FLASH_CE_N(FLASH_CE_N), .FLASH_OE_N(FLASH_OE_N), .FLASH_WE_N(FLASH_WE_N),
  .FLASH_RESET_N(FLASH_RESET_N));
